// >>> src/smp_pkg.sv
/*
 * Shared constants of the serial poll port: command codes, check bytes,
 * group lengths, configuration layout and timing counts.
 * Assumes a 20 MHz core clock.
 */
package smp_pkg;
    // Addressed header prefix in the top nibble of the first byte
    localparam logic [3:0]  ADDR_PREFIX        = 4'h8;

    localparam logic [7:0]  CMD_WRITE_CONFIG   = 8'h01;
    localparam logic [7:0]  CMD_READ_CONFIG    = 8'h02;
    localparam logic [7:0]  CMD_READ_ALL_CELLS = 8'h04;
    localparam logic [7:0]  CMD_READ_CELLS_LOW = 8'h06;
    localparam logic [7:0]  CMD_READ_CELLS_MID = 8'h08;
    localparam logic [7:0]  CMD_READ_CELLS_HI  = 8'h0A;
    localparam logic [7:0]  CMD_READ_FLAG      = 8'h0C;
    localparam logic [7:0]  CMD_ADC_POLL       = 8'h40;
    localparam logic [7:0]  CMD_INT_POLL       = 8'h50;
    localparam logic [7:0]  CMD_READ_DIAG      = 8'h54;

    // Check bytes of fixed command codes
    localparam logic [7:0]  PEC_WRITE_CONFIG   = 8'hC7;
    localparam logic [7:0]  PEC_READ_CELLS_HI  = 8'hF6;
    localparam logic [7:0]  PEC_READ_FLAG      = 8'hE4;

    // Byte counts of each group
    localparam logic [4:0]  LEN_CONFIG         = 5'h06;
    localparam logic [4:0]  LEN_ALL_CELLS      = 5'h12;
    localparam logic [4:0]  LEN_CELL_PART      = 5'h06;
    localparam logic [4:0]  LEN_FLAG           = 5'h03;
    localparam logic [4:0]  LEN_DIAG           = 5'h02;

    localparam logic [7:0]  CRC_SEED           = 8'h41;

    localparam int          CFG_BITS           = 48;
    localparam logic [47:0] CFG_RESET          = 48'h0000_0000_0000;
    localparam int          CFG_LEVEL_POLL_BIT = 4;
    localparam int          DIAG_REV_LSB       = 4;

    localparam int          CLK_FREQ_HZ        = 20_000_000;
    localparam int          TOGGLE_FREQ_HZ     = 1000;
    localparam int          TOGGLE_HALF_CYC    = CLK_FREQ_HZ / (2 * TOGGLE_FREQ_HZ);

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_HDR     = 4'h1,
        ST_HDR_PEC = 4'h2,
        ST_CMD     = 4'h3,
        ST_CMD_PEC = 4'h4,
        ST_RX      = 4'h5,
        ST_TX      = 4'h6,
        ST_POLL    = 4'h7,
        ST_IGNORE  = 4'h8
    } smp_state_t;
endpackage

// >>> src/smp_crc8.sv
/*
 * Serial 8-bit check code, one bit per strobe, MSB first.
 * Assumes strobes come from logic on the same clock.
 */
`timescale 1ns/1ns
module smp_crc8
    import smp_pkg::*;
(
    input  wire logic       clk_in,   // Core clock
    input  wire logic       rst_in,   // Sync reset, high
    input  wire logic       clear_in, // Reload seed
    input  wire logic       shift_in, // Take one bit
    input  wire logic       bit_in,   // Bit to take
    output logic [7:0]      crc_out   // Current code
);
    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;
    wire        fb = bit_in ^ crc_ff[7];

    assign nxt_crc = {crc_ff[6:2], crc_ff[1] ^ fb, crc_ff[0] ^ fb, fb};
    assign crc_out = crc_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in || clear_in) begin
            crc_ff <= CRC_SEED;
        end else if (shift_in) begin
            crc_ff <= nxt_crc;
        end
    end

    crc_seed_a: assert property (@(posedge clk_in) disable iff (rst_in)
        clear_in |=> crc_ff == CRC_SEED)
        else $error("check code not reseeded");
endmodule

// >>> src/smp_toggle_gen.sv
/*
 * Free-running square wave for toggle polling.
 * Assumes HALF_CYC core cycles per half period.
 */
`timescale 1ns/1ns
module smp_toggle_gen #(
    parameter int HALF_CYC = 10000
) (
    input  wire logic clk_in,    // Core clock
    input  wire logic rst_in,    // Sync reset, high
    output logic      toggle_out // 50 percent square wave
);
    localparam int CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_ff;
    logic          tgl_ff;
    wire           wrap = (cnt_ff == LAST);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_ff <= '0;
            tgl_ff <= 1'b0;
        end else begin
            cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
            tgl_ff <= wrap ? ~tgl_ff : tgl_ff;
        end
    end

    assign toggle_out = tgl_ff;

    tgl_period_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(tgl_ff) |-> $past(cnt_ff) == LAST)
        else $error("toggle edge off its half period");
endmodule

// >>> src/smp_poll_port.sv
/*
 * Serial command port with status polling: frames broadcast and addressed
 * packets, checks their codes, serves reads, takes configuration writes
 * and drives the data line while polling.
 * Assumes pins come from another clock domain; busy, interrupt and read
 * data come from logic on the core clock.
 */
`timescale 1ns/1ns
module smp_poll_port #(
    parameter int         TOGGLE_HALF = smp_pkg::TOGGLE_HALF_CYC,
    parameter logic [1:0] REV_CODE    = 2'h1 // Arbitrary revision value
) (
    input  wire logic        CLOCK_IN,               // Core clock
    input  wire logic        RST_IN,                 // Sync reset, high
    input  wire logic        CHIP_SELECT_N_IN,       // Frame select pin, low
    input  wire logic        SERIAL_CLOCK_IN,        // Serial clock pin
    input  wire logic        SERIAL_DATA_IN,         // Serial data pin
    output logic             SERIAL_DATA_OUT,        // Data line value
    output logic             SERIAL_DATA_OE_OUT,     // Data line drive enable
    input  wire logic [3:0]  DEVICE_ADDRESS_PINS_IN, // Part address pins
    input  wire logic        TOP_OF_STACK_SELECT_IN, // Top device strap
    input  wire logic        ADC_BUSY_IN,            // Conversion running
    input  wire logic        INTERRUPT_IN,           // Over/under voltage
    input  wire logic [7:0]  READ_BYTE_IN,           // Byte of selected group
    input  wire logic [13:0] DIAG_DATA_IN,           // Diagnostic data
    output logic [7:0]       READ_CMD_OUT,           // Group being read
    output logic [4:0]       READ_INDEX_OUT,         // Byte wanted
    output logic [smp_pkg::CFG_BITS-1:0] CONFIG_OUT, // Configuration group
    output logic             CONFIG_LOAD_OUT         // Config updated pulse
);
    import smp_pkg::*;

    function automatic logic [4:0] group_len(input logic [7:0] cmd);
        case (cmd)
            CMD_READ_CONFIG:    group_len = LEN_CONFIG;
            CMD_READ_ALL_CELLS: group_len = LEN_ALL_CELLS;
            CMD_READ_CELLS_LOW: group_len = LEN_CELL_PART;
            CMD_READ_CELLS_MID: group_len = LEN_CELL_PART;
            CMD_READ_CELLS_HI:  group_len = LEN_CELL_PART;
            CMD_READ_FLAG:      group_len = LEN_FLAG;
            CMD_READ_DIAG:      group_len = LEN_DIAG;
            default:            group_len = 5'h00;
        endcase
    endfunction

    function automatic smp_state_t dispatch(input logic [7:0] cmd);
        if (cmd == CMD_WRITE_CONFIG) begin
            dispatch = ST_RX;
        end else if (cmd == CMD_ADC_POLL || cmd == CMD_INT_POLL) begin
            dispatch = ST_POLL;
        end else if (group_len(cmd) != 5'h00) begin
            dispatch = ST_TX;
        end else begin
            dispatch = ST_IGNORE;
        end
    endfunction

    // Pin synchronisers
    logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
    logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
    logic sdi_s1_ff, sdi_s2_ff;
    logic [3:0] adr_s1_ff, adr_s2_ff;
    logic tos_s1_ff, tos_s2_ff;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            {sck_s1_ff, sck_s2_ff, sck_s3_ff} <= 3'h7;
            {cs_s1_ff, cs_s2_ff, cs_s3_ff}    <= 3'h7;
            {sdi_s1_ff, sdi_s2_ff}            <= 2'h0;
            {adr_s1_ff, adr_s2_ff, tos_s1_ff, tos_s2_ff} <= 10'h000;
        end else begin
            {sck_s1_ff, sck_s2_ff, sck_s3_ff} <= {SERIAL_CLOCK_IN, sck_s1_ff, sck_s2_ff};
            {cs_s1_ff, cs_s2_ff, cs_s3_ff}    <= {CHIP_SELECT_N_IN, cs_s1_ff, cs_s2_ff};
            {sdi_s1_ff, sdi_s2_ff}            <= {SERIAL_DATA_IN, sdi_s1_ff};
            {adr_s1_ff, adr_s2_ff}            <= {DEVICE_ADDRESS_PINS_IN, adr_s1_ff};
            {tos_s1_ff, tos_s2_ff}            <= {TOP_OF_STACK_SELECT_IN, tos_s1_ff};
        end
    end

    wire cs_high = cs_s2_ff;
    wire cs_rise = cs_s2_ff & ~cs_s3_ff;
    wire sck_rise = sck_s2_ff & ~sck_s3_ff & ~cs_high;
    wire sck_fall = ~sck_s2_ff & sck_s3_ff & ~cs_high;

    // Frame state
    smp_state_t st_ff, nxt_st;
    logic [7:0]  sh_ff;
    logic [2:0]  bit_ff;
    logic [4:0]  idx_ff;
    logic [4:0]  len_ff;
    logic [7:0]  cmd_ff;
    logic        addr_ff;
    logic        wr_ok_ff;
    logic [47:0] wbuf_ff;
    logic [47:0] cfg_ff;
    logic        load_ff;
    logic [7:0]  tx_sh_ff;
    logic        sdo_ff, oe_ff;
    logic        nxt_sdo, nxt_oe;

    wire [7:0] rx_byte  = {sh_ff[6:0], sdi_s2_ff};
    wire       byte_end = sck_rise & (bit_ff == 3'h7);
    wire [7:0] rx_crc;
    wire [7:0] tx_crc;
    wire       toggle;

    wire rx_data_bit = sck_rise & (st_ff == ST_HDR || st_ff == ST_CMD
                       || (st_ff == ST_RX && idx_ff < LEN_CONFIG));
    wire rx_crc_clr  = (cs_s2_ff == 1'b0 && cs_s3_ff == 1'b1)
                       || (byte_end && (st_ff == ST_HDR_PEC || st_ff == ST_CMD_PEC));
    wire pec_ok      = (rx_byte == rx_crc);
    wire addr_hdr    = (cmd_ff[7:4] == ADDR_PREFIX);
    wire addr_match  = addr_hdr && (cmd_ff[3:0] == adr_s2_ff);

    // Group byte source; revision sits inside the checked stream
    wire [7:0] diag_byte = (idx_ff == 5'h00) ? DIAG_DATA_IN[7:0]
                         : {DIAG_DATA_IN[13:12], REV_CODE, DIAG_DATA_IN[11:8]};
    wire [7:0] cfg_byte  = cfg_ff[{idx_ff[2:0], 3'h0} +: 8];
    wire [7:0] grp_byte  = (cmd_ff == CMD_READ_CONFIG) ? cfg_byte
                         : (cmd_ff == CMD_READ_DIAG) ? diag_byte : READ_BYTE_IN;
    wire       tx_data   = (idx_ff < len_ff);
    wire [7:0] tx_load   = tx_data ? grp_byte : tx_crc;
    wire       tx_bit    = (bit_ff == 3'h0) ? tx_load[7] : tx_sh_ff[7];
    wire       tx_shift  = (st_ff == ST_TX) & sck_fall & tx_data;
    wire       tx_clr    = (st_ff != ST_TX);

    smp_crc8 u_rx_crc (
        .clk_in   (CLOCK_IN),
        .rst_in   (RST_IN),
        .clear_in (rx_crc_clr),
        .shift_in (rx_data_bit),
        .bit_in   (sdi_s2_ff),
        .crc_out  (rx_crc)
    );

    smp_crc8 u_tx_crc (
        .clk_in   (CLOCK_IN),
        .rst_in   (RST_IN),
        .clear_in (tx_clr),
        .shift_in (tx_shift),
        .bit_in   (tx_bit),
        .crc_out  (tx_crc)
    );

    smp_toggle_gen #(
        .HALF_CYC (TOGGLE_HALF)
    ) u_toggle (
        .clk_in     (CLOCK_IN),
        .rst_in     (RST_IN),
        .toggle_out (toggle)
    );

    // Next frame state
    always_comb begin
        nxt_st = st_ff;
        if (cs_high) begin
            nxt_st = ST_IDLE;
        end else begin
            case (st_ff)
                ST_IDLE:    nxt_st = ST_HDR;
                ST_HDR:     nxt_st = byte_end ? ST_HDR_PEC : ST_HDR;
                ST_HDR_PEC: begin
                    if (byte_end) begin
                        if (!pec_ok) begin
                            nxt_st = ST_IGNORE;
                        end else if (addr_hdr) begin
                            nxt_st = ST_CMD;
                        end else begin
                            nxt_st = dispatch(cmd_ff);
                        end
                    end
                end
                ST_CMD:     nxt_st = byte_end ? ST_CMD_PEC : ST_CMD;
                ST_CMD_PEC: begin
                    if (byte_end) begin
                        nxt_st = (pec_ok && addr_ff) ? dispatch(cmd_ff) : ST_IGNORE;
                    end
                end
                ST_RX:      nxt_st = (byte_end && idx_ff == LEN_CONFIG) ? ST_IGNORE : ST_RX;
                ST_TX: begin
                    if (sck_fall && bit_ff == 3'h0 && idx_ff > len_ff) begin
                        nxt_st = ST_IGNORE;
                    end
                end
                ST_POLL, ST_IGNORE: nxt_st = st_ff;
                default:    nxt_st = ST_IDLE;
            endcase
        end
    end

    // Poll line drive
    wire level_mode = cfg_ff[CFG_LEVEL_POLL_BIT];
    wire busy_sel   = (cmd_ff == CMD_ADC_POLL) ? ADC_BUSY_IN : INTERRUPT_IN;

    always_comb begin
        nxt_sdo = 1'b1;
        nxt_oe  = 1'b0;
        case (nxt_st)
            ST_TX: begin
                nxt_sdo = sck_fall ? tx_bit : sdo_ff;
                nxt_oe  = 1'b1;
            end
            ST_POLL: begin
                if (busy_sel) begin
                    nxt_sdo = 1'b0;
                    nxt_oe  = 1'b1;
                end else if (!level_mode && (addr_ff || tos_s2_ff)) begin
                    nxt_sdo = toggle;
                    nxt_oe  = 1'b1;
                end else begin
                    nxt_oe  = 1'b0;
                end
            end
            default: nxt_oe = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            st_ff  <= ST_IDLE;
            sdo_ff <= 1'b1;
            oe_ff  <= 1'b0;
        end else begin
            st_ff  <= nxt_st;
            sdo_ff <= nxt_sdo;
            oe_ff  <= nxt_oe;
        end
    end

    // Receive shifter, counters, command capture
    wire        new_field = (st_ff != nxt_st);
    wire [4:0]  tx_idx_n  = (bit_ff == 3'h7) ? idx_ff + 5'h01 : idx_ff;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN || cs_high) begin
            sh_ff  <= 8'h00;
            bit_ff <= 3'h0;
            idx_ff <= 5'h00;
        end else if (st_ff == ST_TX) begin
            bit_ff <= sck_fall ? bit_ff + 3'h1 : bit_ff;
            idx_ff <= sck_fall ? tx_idx_n : idx_ff;
        end else if (sck_rise) begin
            sh_ff  <= rx_byte;
            bit_ff <= bit_ff + 3'h1;
            idx_ff <= (st_ff == ST_RX && byte_end) ? idx_ff + 5'h01 : idx_ff;
        end else if (new_field) begin
            idx_ff <= 5'h00;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            tx_sh_ff <= 8'h00;
        end else if (tx_shift || (st_ff == ST_TX && sck_fall)) begin
            tx_sh_ff <= (bit_ff == 3'h0) ? {tx_load[6:0], 1'b0} : {tx_sh_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN || (cs_high && !cs_rise)) begin
            cmd_ff  <= 8'h00;
            len_ff  <= 5'h00;
            addr_ff <= 1'b0;
        end else if (byte_end && (st_ff == ST_HDR || st_ff == ST_CMD)) begin
            cmd_ff  <= rx_byte;
            len_ff  <= group_len(rx_byte);
        end else if (byte_end && st_ff == ST_HDR_PEC) begin
            addr_ff <= pec_ok && addr_match;
        end
    end

    // Write buffer and commit on frame end
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            wbuf_ff  <= CFG_RESET;
            wr_ok_ff <= 1'b0;
        end else if (cs_s2_ff == 1'b0 && cs_s3_ff == 1'b1) begin
            wr_ok_ff <= 1'b0;
        end else if (byte_end && st_ff == ST_RX) begin
            if (idx_ff < LEN_CONFIG) begin
                wbuf_ff[{idx_ff[2:0], 3'h0} +: 8] <= rx_byte;
            end else begin
                wr_ok_ff <= pec_ok;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            cfg_ff  <= CFG_RESET;
            load_ff <= 1'b0;
        end else begin
            cfg_ff  <= (cs_rise && wr_ok_ff) ? wbuf_ff : cfg_ff;
            load_ff <= cs_rise && wr_ok_ff;
        end
    end

    assign SERIAL_DATA_OUT    = sdo_ff;
    assign SERIAL_DATA_OE_OUT = oe_ff;
    assign READ_CMD_OUT       = cmd_ff;
    assign READ_INDEX_OUT     = idx_ff;
    assign CONFIG_OUT         = cfg_ff;
    assign CONFIG_LOAD_OUT    = load_ff;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    wire in_poll = (st_ff == ST_POLL) && !cs_high;

    cs_release_a: assert property (cs_high |=> !oe_ff ##1 !oe_ff)
        else $error("line still driven after select rise");
    tgl_busy_low_a: assert property (in_poll && !level_mode && busy_sel |=> oe_ff && !sdo_ff)
        else $error("busy toggle poll not low");
    tgl_addr_a: assert property (in_poll && !level_mode && !busy_sel && addr_ff
        |=> oe_ff && sdo_ff == $past(toggle))
        else $error("addressed toggle poll not toggling");
    tgl_bcast_a: assert property (in_poll && !level_mode && !busy_sel && !addr_ff
        && !tos_s2_ff |=> !oe_ff)
        else $error("lower device did not release line");
    lvl_busy_a: assert property (in_poll && level_mode && busy_sel |=> oe_ff && !sdo_ff)
        else $error("busy level poll not low");
    lvl_idle_a: assert property (in_poll && level_mode && !busy_sel |=> !oe_ff)
        else $error("idle level poll still driving");
    bad_pec_a: assert property (st_ff == ST_IGNORE |=> !oe_ff)
        else $error("drive after rejected packet");
    cfg_commit_a: assert property (cs_rise && wr_ok_ff |=> cfg_ff == $past(wbuf_ff) && load_ff)
        else $error("write not applied on select rise");
    known_pec_a: assert property (byte_end && pec_ok && st_ff inside {ST_HDR_PEC, ST_CMD_PEC}
        && (cmd_ff == CMD_WRITE_CONFIG || cmd_ff == CMD_READ_CELLS_HI
        || cmd_ff == CMD_READ_FLAG)
        |-> rx_byte == ((cmd_ff == CMD_WRITE_CONFIG) ? PEC_WRITE_CONFIG
        : (cmd_ff == CMD_READ_FLAG) ? PEC_READ_FLAG : PEC_READ_CELLS_HI))
        else $error("command check byte mismatch");
    rev_field_a: assert property (st_ff == ST_TX && cmd_ff == CMD_READ_DIAG
        && idx_ff == 5'h01 |-> grp_byte[DIAG_REV_LSB +: 2] == REV_CODE)
        else $error("revision missing from diagnostic byte");

    poll_toggle_c: cover property (in_poll && !level_mode && oe_ff ##1 $changed(sdo_ff));
    cfg_write_c:   cover property (cs_rise && wr_ok_ff);
    read_end_c:    cover property (st_ff == ST_TX ##1 st_ff == ST_IGNORE);
    addr_poll_c:   cover property (in_poll && addr_ff && level_mode);
endmodule

// >>> dv/smp_host_model.sv
/*
 * Host side of the serial link: frames, mode 3 byte transfers.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/1ns
module smp_host_model (
    output logic      cs_n_out, // Frame select, low
    output logic      sclk_out, // Serial clock, idle high
    output logic      sdi_out,  // Host to device data
    input  wire logic sdo_in    // Resolved data line
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        sdi_out  = 1'b0;
    end

    task automatic start_frame();
        #400;
        cs_n_out = 1'b0;
        #400;
    endtask

    // Raising select is the only way out of a poll
    task automatic end_frame();
        #400;
        cs_n_out = 1'b1;
        sdi_out  = ~sdi_out;
        #400;
    endtask

    // Change on fall, device takes on rise, MSB first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_out = 1'b0;
            sdi_out  = tx[i];
            #250;
            sclk_out = 1'b1;
            rx[i]    = sdo_in;
            #150;
        end
    endtask
endmodule

// >>> dv/smp_poll_port_tb_top.sv
/*
 * Bench of the serial poll port: read table, config write, refusals, polls.
 * Assumes one device on the bus and a pull-up on the data line.
 */
`timescale 1ns/1ns
module smp_poll_port_tb_top;
    import smp_pkg::*;
    typedef struct packed {logic [7:0] cmd; logic [4:0] len; logic adr;} smp_row_t;
    localparam int HALF = 8;
    logic        clk, rst, busy, intr, top, cs_n, sclk, sdi, sdo, oe, load, oe_seen;
    logic [3:0]  addr;
    logic [13:0] diag;
    logic [7:0]  rcmd, rx;
    logic [4:0]  ridx;
    logic [47:0] cfg, cfg_exp;
    int          miscompares, tests_run, loads;
    wire         line = oe ? sdo : 1'b1;
    wire [7:0]   rbyte = rcmd ^ {3'h0, ridx} ^ 8'hA5;
    // Single device on the bus, so broadcast reads are safe
    smp_row_t rows [7] = '{{CMD_READ_CONFIG, LEN_CONFIG, 1'b0},
        {CMD_READ_ALL_CELLS, LEN_ALL_CELLS, 1'b0}, {CMD_READ_CELLS_LOW, LEN_CELL_PART, 1'b1},
        {CMD_READ_CELLS_MID, LEN_CELL_PART, 1'b0}, {CMD_READ_CELLS_HI, LEN_CELL_PART, 1'b1},
        {CMD_READ_FLAG, LEN_FLAG, 1'b0}, {CMD_READ_DIAG, LEN_DIAG, 1'b1}};

    smp_poll_port #(.TOGGLE_HALF(HALF), .REV_CODE(2'h2)) dut (
        .CLOCK_IN(clk), .RST_IN(rst), .CHIP_SELECT_N_IN(cs_n), .SERIAL_CLOCK_IN(sclk),
        .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OE_OUT(oe),
        .DEVICE_ADDRESS_PINS_IN(addr), .TOP_OF_STACK_SELECT_IN(top), .ADC_BUSY_IN(busy),
        .INTERRUPT_IN(intr), .READ_BYTE_IN(rbyte), .DIAG_DATA_IN(diag), .READ_CMD_OUT(rcmd),
        .READ_INDEX_OUT(ridx), .CONFIG_OUT(cfg), .CONFIG_LOAD_OUT(load));
    smp_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(line));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (oe === 1'b1) oe_seen <= 1'b1;
        if (load === 1'b1) loads <= loads + 1;
    end

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic in0;
        for (int i = 7; i >= 0; i--) begin
            in0 = d[i] ^ c[7];
            c = {c[6:2], c[1] ^ in0, c[0] ^ in0, in0};
        end
        return c;
    endfunction
    function automatic logic [7:0] exp_byte(input logic [7:0] c, input logic [4:0] i);
        if (c == CMD_READ_CONFIG) return cfg_exp[8*i +: 8];
        if (c == CMD_READ_DIAG) return i[0] ? {diag[13:12], 2'h2, diag[11:8]} : diag[7:0];
        return c ^ {3'h0, i} ^ 8'hA5;
    endfunction
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Header, optionally addressed; x spoils the command check byte
    task automatic hdr(input logic [7:0] c, input logic adr, input logic [3:0] a,
                       input logic [7:0] x);
        host.start_frame();
        if (adr) host.xfer({ADDR_PREFIX, a}, rx);
        if (adr) host.xfer(crc8(CRC_SEED, {ADDR_PREFIX, a}), rx);
        host.xfer(c, rx);
        host.xfer(crc8(CRC_SEED, c) ^ x, rx);
    endtask
    task automatic read_row(input smp_row_t r);
        logic [7:0] c;
        logic [7:0] e;
        c = CRC_SEED;
        hdr(r.cmd, r.adr, addr, 8'h00);
        for (int i = 0; i < r.len; i++) begin
            host.xfer(8'hFF, rx);
            e = exp_byte(r.cmd, i[4:0]);
            chk("read_data", e, rx);
            c = crc8(c, e);
        end
        host.xfer(8'hFF, rx);
        chk("read_pec", c, rx);
        chk("read_cmd", r.cmd, rcmd);
        host.end_frame();
        $display("read test %h done", r.cmd);
    endtask
    task automatic write_cfg(input logic [47:0] v, input logic [7:0] x);
        logic [7:0] c;
        c = CRC_SEED;
        hdr(CMD_WRITE_CONFIG, 1'b0, addr, 8'h00);
        for (int i = 0; i < 6; i++) begin
            host.xfer(v[8*i +: 8], rx);
            c = crc8(c, v[8*i +: 8]);
        end
        host.xfer(c ^ x, rx);
        host.end_frame();
    endtask
    task automatic silent(input logic [7:0] c, input logic [3:0] a, input logic [7:0] x);
        oe_seen = 1'b0;
        hdr(c, 1'b1, a, x);
        repeat (3) host.xfer(8'hFF, rx);
        host.end_frame();
        chk("silent_oe", 0, oe_seen);
    endtask
    task automatic poll(input logic [7:0] c, input logic adr, input logic b, input logic i,
                        input logic eoe, input logic el, input int etg);
        int   tg;
        logic p;
        @(posedge clk);
        #1 busy = b;
        intr = i;
        hdr(c, adr, addr, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk("poll_oe", eoe, oe);
        if (etg == 0) chk("poll_line", el, line);
        tg = 0;
        p = line;
        repeat (16 * HALF) begin
            @(posedge clk);
            #1 if (line !== p) tg++;
            p = line;
        end
        chk("poll_toggles", etg, tg);
        host.end_frame();
        chk("poll_exit_oe", 0, oe);
        $display("poll test %h done", c);
    endtask

    initial begin
        #2000000;
        miscompares++;
        end_sim();
    end
    initial begin
        {rst, busy, intr, top, addr, diag} = {4'h9, 4'h5, 14'h2A5C};
        {miscompares, tests_run, loads, oe_seen, cfg_exp} = '0;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        chk("rst_oe", 0, oe);
        chk("rst_sdo", 1, sdo);
        chk("rst_cfg", 0, {cfg[47:1], load});
        $display("reset test done");
        foreach (rows[k]) read_row(rows[k]);
        cfg_exp = 48'hC3B2A1908F0E;
        write_cfg(cfg_exp, 8'h00);
        chk("cfg_write", cfg_exp, cfg);
        chk("cfg_loads", 1, loads);
        write_cfg(48'h1, 8'h01);
        chk("cfg_bad_pec", cfg_exp, cfg);
        read_row(rows[0]);
        silent(CMD_READ_CONFIG, addr, 8'h01);
        silent(CMD_READ_CONFIG, addr ^ 4'h1, 8'h00);
        $display("refusal test done");
        poll(CMD_ADC_POLL, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 0);
        poll(CMD_ADC_POLL, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16);
        poll(CMD_INT_POLL, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 0);
        poll(CMD_INT_POLL, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16);
        top = 1'b0;
        poll(CMD_ADC_POLL, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 0);
        cfg_exp[CFG_LEVEL_POLL_BIT] = 1'b1;
        write_cfg(cfg_exp, 8'h00);
        poll(CMD_ADC_POLL, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 0);
        poll(CMD_ADC_POLL, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 0);
        poll(CMD_INT_POLL, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 0);
        poll(CMD_INT_POLL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 0);
        end_sim();
    end
endmodule
